// ---- rtl/rmsl_regs.vh ----
`ifndef RMSL_REGS_VH
`define RMSL_REGS_VH

// ----------------------------------------
// Functionality levels
// ----------------------------------------
`define RMSL_FUN_MIN 3'h0
`define RMSL_FUN_RADIO 3'h1
`define RMSL_FUN_FLIGHT 3'h4
`define RMSL_FUN_RESET 3'h1

// ----------------------------------------
// Radio modes reported out
// ----------------------------------------
`define RMSL_MODE_MIN 2'h0
`define RMSL_MODE_RADIO 2'h1
`define RMSL_MODE_FLIGHT 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define RMSL_CLK_HZ 50000000
`define RMSL_TICK_MS 1
`define RMSL_CYC_PER_MS ((`RMSL_CLK_HZ / 1000) * `RMSL_TICK_MS)
`define RMSL_HALF_5G_MS 100
`define RMSL_HALF_4G_MS 200
`define RMSL_HALF_3G_MS 800

`endif

// ---- rtl/rmsl_ms_tick.v ----
`timescale 1ns/100ps
`include "rmsl_regs.vh"

// Millisecond tick generator; restart realigns phase.
module rmsl_ms_tick #(
    parameter CYC_PER_MS = `RMSL_CYC_PER_MS,
    parameter CW = 16
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire restart_in,
    output reg tick_out
);
    reg [CW-1:0] cnt_r;
    localparam integer LAST_INT = CYC_PER_MS - 1;
    localparam [CW-1:0] LAST = LAST_INT[CW-1:0];

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_r <= {CW{1'b0}};
            tick_out <= 1'b0;
        end else if (clk_en_in) begin
            if (restart_in || cnt_r == LAST) begin
                cnt_r <= {CW{1'b0}};
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
            tick_out <= !restart_in && (cnt_r == LAST);
        end
    end
endmodule

// ---- rtl/rmsl_top.v ----
`timescale 1ns/100ps
`include "rmsl_regs.vh"

// Function
// - Hold the indicator steadily on while searching or while a call is connected.
// - Blink 100 ms on and 100 ms off for 5G data or 5G registration.
// - Blink 200 ms on and 200 ms off for 3G/4G data or 4G registration.
// - Blink 800 ms on and 800 ms off for 3G registration.
// - Hold the indicator off while powered down or asleep.
// - The radio-disable input is active low and low means flight mode with radio off.
// - With disable high, follow the commanded level: 0 minimal, 4 flight, 1 radio (default).
// - The disable input overrides any commanded level.
module rmsl_top #(
    parameter CYC_PER_MS = `RMSL_CYC_PER_MS,
    parameter HALF_5G_MS = `RMSL_HALF_5G_MS,
    parameter HALF_4G_MS = `RMSL_HALF_4G_MS,
    parameter HALF_3G_MS = `RMSL_HALF_3G_MS
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire radio_disable_n_in,
    input wire fun_cmd_valid_in,
    input wire [2:0] functionality_level_command_in,
    input wire searching_in,
    input wire call_active_in,
    input wire data_5g_in,
    input wire reg_5g_in,
    input wire data_3g4g_in,
    input wire reg_4g_in,
    input wire reg_3g_in,
    input wire power_down_in,
    input wire sleep_in,
    output reg [2:0] fun_level_out,
    output reg [1:0] radio_mode_out,
    output reg radio_en_out,
    output reg sim_en_out,
    output reg net_led_out
);
    // ----------------------------------------
    // Pattern states, one-hot
    // ----------------------------------------
    localparam [4:0] PAT_OFF = 5'h01;
    localparam [4:0] PAT_ON = 5'h02;
    localparam [4:0] PAT_B100 = 5'h04;
    localparam [4:0] PAT_B200 = 5'h08;
    localparam [4:0] PAT_B800 = 5'h10;

    reg [4:0] pat_r;
    reg [4:0] pat_nxt;
    reg [9:0] ms_r;
    reg [9:0] ms_nxt;
    reg [9:0] half_ms;
    reg phase_r;
    reg phase_nxt;
    reg [2:0] fun_nxt;
    reg [1:0] mode_nxt;
    reg radio_en_nxt;
    reg sim_en_nxt;
    reg led_nxt;
    wire tick;
    wire pat_chg;
    wire want_off;
    wire want_on;
    wire want_b100;
    wire want_b200;
    wire want_b800;
    wire is_blink;
    wire half_end;

    // ----------------------------------------
    // Status decode
    // ----------------------------------------
    // Power state sits above every network state
    assign want_off = power_down_in || sleep_in;
    assign want_on = searching_in || call_active_in;
    assign want_b100 = data_5g_in || reg_5g_in;
    assign want_b200 = data_3g4g_in || reg_4g_in;
    assign want_b800 = reg_3g_in;
    assign pat_chg = (pat_nxt != pat_r);
    assign is_blink = (pat_r == PAT_B100) || (pat_r == PAT_B200) || (pat_r == PAT_B800);
    assign half_end = (ms_r == half_ms - 10'h001);

    // ----------------------------------------
    // Functionality level and radio mode
    // ----------------------------------------
    always @* begin
        mode_nxt = `RMSL_MODE_RADIO;
        if (!radio_disable_n_in) begin
            mode_nxt = `RMSL_MODE_FLIGHT;
        end else begin
            case (fun_level_out)
                `RMSL_FUN_MIN: mode_nxt = `RMSL_MODE_MIN;
                `RMSL_FUN_FLIGHT: mode_nxt = `RMSL_MODE_FLIGHT;
                default: mode_nxt = `RMSL_MODE_RADIO;
            endcase
        end
        radio_en_nxt = (mode_nxt == `RMSL_MODE_RADIO);
        sim_en_nxt = (mode_nxt != `RMSL_MODE_MIN);
    end

    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    // Unsupported levels are dropped; last good level is kept
    always @* begin
        fun_nxt = fun_level_out;
        if (fun_cmd_valid_in) begin
            case (functionality_level_command_in)
                `RMSL_FUN_MIN: fun_nxt = `RMSL_FUN_MIN;
                `RMSL_FUN_RADIO: fun_nxt = `RMSL_FUN_RADIO;
                `RMSL_FUN_FLIGHT: fun_nxt = `RMSL_FUN_FLIGHT;
                default: fun_nxt = fun_level_out;
            endcase
        end
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            fun_level_out <= `RMSL_FUN_RESET;
            radio_mode_out <= `RMSL_MODE_RADIO;
            radio_en_out <= 1'b0;
            sim_en_out <= 1'b0;
        end else if (clk_en_in) begin
            fun_level_out <= fun_nxt;
            radio_mode_out <= mode_nxt;
            radio_en_out <= radio_en_nxt;
            sim_en_out <= sim_en_nxt;
        end
    end

    // ----------------------------------------
    // Pattern selection
    // ----------------------------------------
    always @* begin
        if (want_off) begin
            pat_nxt = PAT_OFF;
        end else if (want_on) begin
            pat_nxt = PAT_ON;
        end else if (want_b100) begin
            pat_nxt = PAT_B100;
        end else if (want_b200) begin
            pat_nxt = PAT_B200;
        end else if (want_b800) begin
            pat_nxt = PAT_B800;
        end else begin
            pat_nxt = PAT_OFF;
        end
    end

    always @* begin
        case (pat_r)
            PAT_B100: half_ms = HALF_5G_MS[9:0];
            PAT_B200: half_ms = HALF_4G_MS[9:0];
            PAT_B800: half_ms = HALF_3G_MS[9:0];
            default: half_ms = 10'h3FF;
        endcase
    end

    // ----------------------------------------
    // Millisecond base
    // ----------------------------------------
    // Restart on each pattern change keeps the first on phase full length
    rmsl_ms_tick #(
        .CYC_PER_MS(CYC_PER_MS),
        .CW(16)
    ) u_tick (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .restart_in(pat_chg),
        .tick_out(tick)
    );

    // ----------------------------------------
    // Blink engine
    // ----------------------------------------
    always @* begin
        ms_nxt = ms_r;
        phase_nxt = phase_r;
        if (pat_chg) begin
            // Fresh pattern always opens with a full on phase
            ms_nxt = 10'h000;
            phase_nxt = 1'b1;
        end else if (tick && is_blink) begin
            if (half_end) begin
                ms_nxt = 10'h000;
                phase_nxt = ~phase_r;
            end else begin
                ms_nxt = ms_r + 10'h001;
            end
        end
    end

    // ----------------------------------------
    // Indicator drive
    // ----------------------------------------
    // LED follows the phase it is entering, so it does not trail the toggle by a cycle
    always @* begin
        case (pat_nxt)
            PAT_ON: led_nxt = 1'b1;
            PAT_OFF: led_nxt = 1'b0;
            default: led_nxt = phase_nxt;
        endcase
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pat_r <= PAT_OFF;
            ms_r <= 10'h000;
            phase_r <= 1'b1;
            net_led_out <= 1'b0;
        end else if (clk_en_in) begin
            pat_r <= pat_nxt;
            ms_r <= ms_nxt;
            phase_r <= phase_nxt;
            net_led_out <= led_nxt;
        end
    end
endmodule

// ---- testbench/rmsl_led_mon.sv ----
`timescale 1ns/100ps
// ----
// LED side: measures each lit run
// ----
module rmsl_led_mon (
    input wire clk_in,
    input wire led_in,
    output reg [15:0] on_len_out = 16'h0
);
    reg [15:0] run_r = 16'h0;
    always @(posedge clk_in) begin
        run_r <= led_in ? run_r + 16'h1 : 16'h0;
        if (!led_in && run_r != 16'h0) begin
            on_len_out <= run_r;
        end
    end
endmodule

// ---- testbench/rmsl_top_assertions.sv ----
`timescale 1ns/100ps
module rmsl_chk (
    input wire clk_in,
    input wire sys_rst_in,
    input wire clk_en_in,
    input wire radio_disable_n_in,
    input wire fun_cmd_valid_in,
    input wire [2:0] functionality_level_command_in,
    input wire searching_in,
    input wire call_active_in,
    input wire data_5g_in,
    input wire reg_5g_in,
    input wire data_3g4g_in,
    input wire reg_4g_in,
    input wire reg_3g_in,
    input wire power_down_in,
    input wire sleep_in,
    input wire [2:0] fun_level_out,
    input wire [1:0] radio_mode_out,
    input wire radio_en_out,
    input wire sim_en_out,
    input wire net_led_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire e = clk_en_in;
    wire pwr = power_down_in | sleep_in;
    wire hi = searching_in | call_active_in;
    wire [2:0] c = functionality_level_command_in;
    wire ok = c == 3'h0 || c == 3'h1 || c == 3'h4;
    sequence s_lit;
        net_led_out [*8];
    endsequence
    AST_OFF: assert property (e && pwr |=> !net_led_out) else $error("led on");
    AST_ON: assert property (e && !pwr && hi |=> net_led_out) else $error("led off");
    AST_START: assert property (e && !pwr && !hi && !data_5g_in && $rose(reg_5g_in)
        |=> s_lit) else $error("blink not on first");
    AST_FLT: assert property (e && !radio_disable_n_in
        |=> radio_mode_out == 2'h2 && !radio_en_out) else $error("no flight");
    AST_LVL: assert property (e && fun_cmd_valid_in && ok
        |=> fun_level_out == $past(c)) else $error("level not taken");
    AST_IGN: assert property (e && fun_cmd_valid_in && !ok
        |=> $stable(fun_level_out)) else $error("bad level taken");
    AST_MIN: assert property (e && radio_disable_n_in && fun_level_out == 3'h0
        |=> radio_mode_out == 2'h0 && !sim_en_out) else $error("not minimal");
    AST_RAD: assert property (e && radio_disable_n_in && fun_level_out == 3'h1
        |=> radio_en_out && radio_mode_out == 2'h1) else $error("radio off");
    AST_SIM: assert property (e && fun_level_out == 3'h4
        |=> sim_en_out && !radio_en_out) else $error("flight wrong");
endmodule
bind rmsl_top rmsl_chk u_chk (.*);

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL %0t %h %h", $time, (a), (b)); end end
module tb_top;
    reg clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg pin_r = 1'b1;
    reg en_r = 1'b1;
    reg vld_r = 1'b0;
    reg [2:0] cmd_r = 3'h0;
    reg [8:0] st_r = 9'h0;
    wire [2:0] fun_level_out;
    wire [1:0] radio_mode_out;
    wire radio_en_out, sim_en_out, net_led_out;
    wire [15:0] on_len;
    int err_total = 0;
    int n_tests = 0;
    int i, n;
    time t0;
    // Ten cycles a millisecond keeps the 800 ms case short
    rmsl_top #(.CYC_PER_MS(10), .HALF_5G_MS(2), .HALF_4G_MS(4), .HALF_3G_MS(8)) DUT (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(en_r),
        .radio_disable_n_in(pin_r), .fun_cmd_valid_in(vld_r),
        .functionality_level_command_in(cmd_r), .searching_in(st_r[8]),
        .call_active_in(st_r[7]), .data_5g_in(st_r[6]), .reg_5g_in(st_r[5]),
        .data_3g4g_in(st_r[4]), .reg_4g_in(st_r[3]), .reg_3g_in(st_r[2]),
        .power_down_in(st_r[1]), .sleep_in(st_r[0]), .fun_level_out(fun_level_out),
        .radio_mode_out(radio_mode_out), .radio_en_out(radio_en_out),
        .sim_en_out(sim_en_out), .net_led_out(net_led_out));
    rmsl_led_mon LED (.clk_in(clk_in), .led_in(net_led_out), .on_len_out(on_len));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task cmd(input [2:0] lv, input [2:0] el, input [1:0] em);
        @(posedge clk_in) vld_r <= 1'b1;
        cmd_r <= lv;
        @(posedge clk_in) vld_r <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(fun_level_out, el)
        `CHK(radio_mode_out, em)
        `CHK(sim_en_out, el != 3'h0)
        `CHK(radio_en_out, em == 2'h1)
    endtask
    task t_pin;
        @(posedge clk_in) pin_r <= 1'b0;
        cmd(3'h1, 3'h1, 2'h2);
        @(posedge clk_in) pin_r <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(radio_mode_out, 2'h1)
    endtask
    // Frozen enable must swallow a valid command
    task t_en;
        @(posedge clk_in) en_r <= 1'b0;
        vld_r <= 1'b1;
        cmd_r <= 3'h0;
        @(posedge clk_in) vld_r <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(fun_level_out, 3'h1)
        `CHK(radio_mode_out, 2'h1)
        @(posedge clk_in) en_r <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(fun_level_out, 3'h1)
        `CHK(radio_en_out, 1'b1)
    endtask
    task wait_led(input v);
        for (i = 0; i < 400 && net_led_out !== v; i++) #20;
        if (i == 400) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    // Park in sleep first so every run starts from dark
    task blink(input [8:0] st, input [15:0] len);
        @(posedge clk_in) st_r <= 9'h001;
        repeat (3) @(posedge clk_in);
        st_r <= st;
        #1;
        wait_led(1'b1);
        wait_led(1'b0);
        #20;
        `CHK(on_len + 16'h1 >= len && on_len <= len + 16'h1, 1'b1)
        t0 = $time;
        wait_led(1'b1);
        `CHK(($time - t0) / 20 + 2 >= len && ($time - t0) / 20 <= len, 1'b1)
    endtask
    task steady;
        @(posedge clk_in) st_r <= 9'h184;
        #41;
        n = 0;
        for (i = 0; i < 200; i++) begin
            #20;
            n += (net_led_out !== 1'b1);
        end
        `CHK(n, 0)
        @(posedge clk_in) st_r <= 9'h186;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(net_led_out, 1'b0)
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        cmd(3'h0, 3'h0, 2'h0);
        cmd(3'h2, 3'h0, 2'h0);
        cmd(3'h4, 3'h4, 2'h2);
        cmd(3'h1, 3'h1, 2'h1);
        $display("done levels");
        t_pin();
        $display("done pin");
        t_en();
        $display("done enable");
        blink(9'h044, 16'h14);
        blink(9'h020, 16'h14);
        blink(9'h010, 16'h28);
        blink(9'h00C, 16'h28);
        blink(9'h004, 16'h50);
        $display("done blink");
        steady();
        $display("done steady");
        tally_and_finish();
    end
endmodule
